// >>> logic/pec_pkg.sv
// constants, register map and types of the pulse and encoder counter
package pec_pkg;
   localparam int CLK_NS = 100;
   localparam int UNIT_NS = 1_000_000;
   localparam int MS_CYC = UNIT_NS / CLK_NS;
   localparam int DEB_NS = 200_000;
   localparam int DEB_CYC = DEB_NS / CLK_NS;
   localparam int NCH = 4;
   localparam logic [47:0] HZ_SCALE = 48'h3e8;
   localparam logic [15:0] SCAN_MS_RST = 16'h03e8;
   localparam logic [15:0] SCAN_WIN_RST = 16'h0000;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SCAN_MS = 8'h04;
   localparam logic [7:0] OFF_SCAN_WIN = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_RES0 = 8'h20;
   localparam logic [7:0] OFF_QNET = 8'h30;
   localparam logic [7:0] OFF_QCW = 8'h34;
   localparam logic [7:0] OFF_QCCW = 8'h38;
   localparam logic [7:0] OFF_PER_TIME = 8'h3c;
   localparam logic [7:0] OFF_PER_NUM = 8'h40;
   localparam int IRQ_SCAN = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_PER = 2;
   localparam int IRQ_W = 3;
   localparam logic [1:0] SEL_COUNT = 2'h0;
   localparam logic [1:0] SEL_FREQ = 2'h1;
   localparam logic [1:0] SEL_AVG = 2'h2;
   localparam logic [1:0] Q_X1 = 2'h0;
   localparam logic [1:0] Q_X2 = 2'h1;
   localparam logic [1:0] Q_X4 = 2'h2;
   typedef struct packed {
      logic [13:0] rsvd;
      logic [1:0] per_src;
      logic [7:0] out_sel;
      logic [3:0] switch_closure_input;
      logic [1:0] quad_mode;
      logic quad_en;
      logic run;
   } pec_ctrl_t;
   typedef struct packed {
      logic [31:0] net;
      logic [31:0] cw;
      logic [31:0] ccw;
   } pec_quad_t;
   typedef enum logic {DV_IDLE, DV_RUN} pec_dv_state_t;
endpackage

// >>> logic/pec_top.sv
// per-scan pulse accumulators, quadrature decoder and period timer with APB registers
module pec_top #(
   parameter int MS_CYC = pec_pkg::MS_CYC // clock cycles per scan millisecond
) (
   input wire logic mclk, // system clock, 10 MHz
   input wire logic rst, // asynchronous reset, active high
   input wire logic [7:0] paddr, // apb byte address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic [3:0] pulse_in, // pulse terminals, 0 and 1 also encoder A and B
   output logic scan_active, // scan window in progress
   output logic irq // level interrupt
);
   localparam int NCH = pec_pkg::NCH;
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (rst);

   pec_pkg::pec_ctrl_t ctrl_reg;
   logic [15:0] scan_ms_reg;
   logic [15:0] scan_win_reg;
   logic [2:0] irq_stat_reg;
   logic [2:0] irq_mask_reg;
   logic [2:0] irq_ev;
   logic wr_en;
   logic [15:0] pre_reg;
   logic [15:0] ms_reg;
   logic scan_tick;
   logic [15:0] win_cnt_reg;
   logic act_reg;
   logic [3:0] in_prev_reg;
   logic [3:0] deb_state_reg;
   logic [11:0] deb_cnt_reg [NCH];
   logic [3:0] edge_ev;
   logic [3:0] wrap_ev;
   logic [31:0] cnt_reg [NCH];
   logic [31:0] cap_reg [NCH];
   logic [3:0] ovf_reg;
   logic [3:0] cap_ovf_reg;
   logic [31:0] freq_reg [NCH];
   logic [31:0] avg_reg [NCH];

   assign wr_en = psel & penable & pwrite;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= pec_pkg::CTRL_RST;
         scan_ms_reg <= pec_pkg::SCAN_MS_RST;
         scan_win_reg <= pec_pkg::SCAN_WIN_RST;
         irq_mask_reg <= '0;
      end else if (wr_en) begin
         case (paddr)
            pec_pkg::OFF_CTRL: ctrl_reg <= {14'h0, pwdata[17:0]};
            pec_pkg::OFF_SCAN_MS: scan_ms_reg <= pwdata[15:0];
            pec_pkg::OFF_SCAN_WIN: scan_win_reg <= pwdata[15:0];
            pec_pkg::OFF_IRQ_MASK: irq_mask_reg <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // scan timebase: millisecond prescaler and scan counter; the window, debounce and period timer count clock cycles
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pre_reg <= '0;
         ms_reg <= '0;
      end else if (!ctrl_reg.run || scan_ms_reg == 16'h0) begin
         pre_reg <= '0;
         ms_reg <= '0;
      end else if (pre_reg == 16'(MS_CYC - 1)) begin
         pre_reg <= '0;
         ms_reg <= (ms_reg == scan_ms_reg - 16'h1) ? 16'h0 : ms_reg + 16'h1;
      end else begin
         pre_reg <= pre_reg + 16'h1;
      end
   end
   assign scan_tick = ctrl_reg.run && scan_ms_reg != 16'h0 &&
      pre_reg == 16'(MS_CYC - 1) && ms_reg == scan_ms_reg - 16'h1;

   // scan execution window, in clock cycles from the tick
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         win_cnt_reg <= '0;
         act_reg <= 1'b0;
      end else if (scan_tick) begin
         win_cnt_reg <= scan_win_reg;
         act_reg <= scan_win_reg != 16'h0;
      end else begin
         win_cnt_reg <= (win_cnt_reg != 16'h0) ? win_cnt_reg - 16'h1 : 16'h0;
         act_reg <= win_cnt_reg > 16'h1;
      end
   end
   assign scan_active = act_reg;

   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            in_prev_reg[ch] <= 1'b0;
            deb_state_reg[ch] <= 1'b1;
            deb_cnt_reg[ch] <= '0;
         end else begin
            in_prev_reg[ch] <= pulse_in[ch];
            if (pulse_in[ch] == deb_state_reg[ch]) begin
               deb_cnt_reg[ch] <= '0;
            end else if (deb_cnt_reg[ch] == 12'(pec_pkg::DEB_CYC - 1)) begin
               deb_state_reg[ch] <= pulse_in[ch];
               deb_cnt_reg[ch] <= '0;
            end else begin
               deb_cnt_reg[ch] <= deb_cnt_reg[ch] + 12'h1;
            end
         end
      end
      // debounced closure edge, or raw rising edge on other inputs
      // closure pulls low; bounce shorter than the filter never lands
      assign edge_ev[ch] = ctrl_reg.switch_closure_input[ch] ?
         (deb_state_reg[ch] && !pulse_in[ch] &&
          deb_cnt_reg[ch] == 12'(pec_pkg::DEB_CYC - 1)) :
         (pulse_in[ch] && !in_prev_reg[ch]);
      assign wrap_ev[ch] = edge_ev[ch] && !scan_tick && cnt_reg[ch] == 32'hffff_ffff;

      // capture and clear
      // an edge on the tick itself opens the next scan's total
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            cnt_reg[ch] <= '0;
            cap_reg[ch] <= '0;
         end else if (scan_tick) begin
            cap_reg[ch] <= cnt_reg[ch];
            cnt_reg[ch] <= {31'h0, edge_ev[ch]};
         end else if (edge_ev[ch]) begin
            cnt_reg[ch] <= cnt_reg[ch] + 32'h1;
         end
      end
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            ovf_reg[ch] <= 1'b0;
            cap_ovf_reg[ch] <= 1'b0;
         end else if (scan_tick) begin
            cap_ovf_reg[ch] <= ovf_reg[ch];
            ovf_reg[ch] <= 1'b0;
         end else if (wrap_ev[ch]) begin
            ovf_reg[ch] <= 1'b1;
         end
      end
   end

   // encoder on inputs 0 and 1
   logic [1:0] qab_prev_reg;
   logic a_chg, b_chg, one_step, q_cw, q_inc, q_dec;
   pec_pkg::pec_quad_t q_reg, q_cap_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         qab_prev_reg <= '0;
      end else begin
         qab_prev_reg <= pulse_in[1:0];
      end
   end
   assign a_chg = pulse_in[0] ^ qab_prev_reg[0];
   assign b_chg = pulse_in[1] ^ qab_prev_reg[1];
   // a double change is a lost step; it is not counted
   assign one_step = ctrl_reg.quad_en && (a_chg ^ b_chg);
   // direction from new A against old B
   assign q_cw = pulse_in[0] ^ qab_prev_reg[1];
   always_comb begin
      q_inc = 1'b0;
      q_dec = 1'b0;
      case (ctrl_reg.quad_mode)
         pec_pkg::Q_X1: begin
            q_inc = one_step && a_chg && pulse_in[0] && q_cw;
            q_dec = one_step && a_chg && !pulse_in[0] && !q_cw;
         end
         pec_pkg::Q_X2: begin
            q_inc = one_step && a_chg && q_cw;
            q_dec = one_step && a_chg && !q_cw;
         end
         pec_pkg::Q_X4: begin
            q_inc = one_step && q_cw;
            q_dec = one_step && !q_cw;
         end
         default: ;
      endcase
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q_reg <= '0;
         q_cap_reg <= '0;
      end else if (scan_tick) begin
         q_cap_reg <= q_reg;
         q_reg.net <= q_inc ? 32'h1 : (q_dec ? 32'hffff_ffff : 32'h0);
         q_reg.cw <= {31'h0, q_inc};
         q_reg.ccw <= {31'h0, q_dec};
      end else if (q_inc) begin
         q_reg.net <= q_reg.net + 32'h1;
         q_reg.cw <= q_reg.cw + 32'h1;
      end else if (q_dec) begin
         q_reg.net <= q_reg.net - 32'h1;
         q_reg.ccw <= q_reg.ccw + 32'h1;
      end
   end

   // frequency divider, one channel after another
   // shared serial divider: 48 cycles per channel instead of four dividers
   pec_pkg::pec_dv_state_t dv_state_reg;
   logic dv_start_reg, scan_done;
   logic [1:0] dv_ch_reg;
   logic [5:0] dv_bit_reg;
   logic [16:0] dv_rem_reg, rem_sh, rem_next;
   logic [47:0] dv_num_reg, dv_quo_reg, q_final;
   logic q_bit;
   logic [31:0] f_sat;
   always_comb begin
      rem_sh = {dv_rem_reg[15:0], dv_num_reg[47]};
      q_bit = rem_sh >= {1'b0, scan_ms_reg};
      rem_next = q_bit ? rem_sh - {1'b0, scan_ms_reg} : rem_sh;
      q_final = {dv_quo_reg[46:0], q_bit};
      f_sat = (q_final[47:32] != 16'h0) ? 32'hffff_ffff : q_final[31:0];
   end
   assign scan_done = dv_state_reg == pec_pkg::DV_RUN && dv_bit_reg == 6'h2f &&
      dv_ch_reg == 2'(NCH - 1);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dv_state_reg <= pec_pkg::DV_IDLE;
         dv_start_reg <= 1'b0;
         dv_ch_reg <= '0;
         dv_bit_reg <= '0;
         dv_rem_reg <= '0;
         dv_num_reg <= '0;
         dv_quo_reg <= '0;
      end else begin
         dv_start_reg <= scan_tick;
         case (dv_state_reg)
            pec_pkg::DV_IDLE: begin
               if (dv_start_reg) begin
                  dv_state_reg <= pec_pkg::DV_RUN;
                  dv_ch_reg <= '0;
                  dv_bit_reg <= '0;
                  dv_rem_reg <= '0;
                  dv_num_reg <= {16'h0, cap_reg[0]} * pec_pkg::HZ_SCALE;
               end
            end
            pec_pkg::DV_RUN: begin
               if (dv_bit_reg == 6'h2f) begin
                  dv_bit_reg <= '0;
                  dv_rem_reg <= '0;
                  dv_ch_reg <= dv_ch_reg + 2'h1;
                  dv_num_reg <= {16'h0, cap_reg[2'(dv_ch_reg + 2'h1)]} * pec_pkg::HZ_SCALE;
                  if (dv_ch_reg == 2'(NCH - 1)) begin
                     dv_state_reg <= pec_pkg::DV_IDLE;
                  end
               end else begin
                  dv_bit_reg <= dv_bit_reg + 6'h1;
                  dv_rem_reg <= rem_next;
                  dv_num_reg <= {dv_num_reg[46:0], 1'b0};
                  dv_quo_reg <= q_final;
               end
            end
            default: dv_state_reg <= pec_pkg::DV_IDLE;
         endcase
      end
   end
   // frequency and running average per channel
   for (genvar ch = 0; ch < NCH; ch++) begin : g_res
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            freq_reg[ch] <= '0;
            avg_reg[ch] <= '0;
         end else if (dv_state_reg == pec_pkg::DV_RUN && dv_bit_reg == 6'h2f &&
                      dv_ch_reg == 2'(ch)) begin
            freq_reg[ch] <= f_sat;
            avg_reg[ch] <= avg_reg[ch] - {2'h0, avg_reg[ch][31:2]} + {2'h0, f_sat[31:2]};
         end
      end
   end

   // period timer on the fast clock
   logic pr_started_reg, pr_fin_reg, pr_edge;
   logic [31:0] pr_cyc_reg, pr_last_reg, pr_time_reg;
   logic [15:0] pr_n_reg, pr_num_reg;
   assign pr_edge = act_reg && pulse_in[ctrl_reg.per_src] && !in_prev_reg[ctrl_reg.per_src];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pr_started_reg <= 1'b0;
         pr_cyc_reg <= '0;
         pr_last_reg <= '0;
         pr_n_reg <= '0;
      end else if (scan_tick) begin
         pr_started_reg <= 1'b0;
         pr_cyc_reg <= '0;
         pr_last_reg <= '0;
         pr_n_reg <= '0;
      end else if (act_reg) begin
         if (pr_started_reg) begin
            pr_cyc_reg <= pr_cyc_reg + 32'h1;
         end
         if (pr_edge && !pr_started_reg) begin
            pr_started_reg <= 1'b1;
         end else if (pr_edge) begin
            pr_n_reg <= pr_n_reg + 16'h1;
            pr_last_reg <= pr_cyc_reg + 32'h1;
         end
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pr_fin_reg <= 1'b0;
         pr_time_reg <= '0;
         pr_num_reg <= '0;
      end else begin
         pr_fin_reg <= act_reg && win_cnt_reg == 16'h1 && !scan_tick;
         if (pr_fin_reg) begin
            pr_time_reg <= pr_last_reg;
            pr_num_reg <= pr_n_reg;
         end
      end
   end

   // interrupt status: a new event wins over a write-one clear
   assign irq_ev[pec_pkg::IRQ_SCAN] = scan_done;
   assign irq_ev[pec_pkg::IRQ_OVF] = |wrap_ev;
   assign irq_ev[pec_pkg::IRQ_PER] = pr_fin_reg;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == pec_pkg::OFF_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[2:0]) | irq_ev;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_ev;
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // apb: read data is latched in the setup cycle, so no wait states
   logic hit;
   logic [31:0] rd_val;
   logic [1:0] rsel;
   logic [1:0] ridx;
   always_comb begin
      hit = 1'b1;
      rd_val = '0;
      ridx = paddr[3:2];
      rsel = ctrl_reg.out_sel[2 * ridx +: 2];
      if (paddr[7:4] == pec_pkg::OFF_RES0[7:4] && paddr[1:0] == 2'h0) begin
         case (rsel)
            pec_pkg::SEL_FREQ: rd_val = freq_reg[ridx];
            pec_pkg::SEL_AVG: rd_val = avg_reg[ridx];
            default: rd_val = cap_reg[ridx];
         endcase
      end else begin
         case (paddr)
            pec_pkg::OFF_CTRL: rd_val = ctrl_reg;
            pec_pkg::OFF_SCAN_MS: rd_val = {16'h0, scan_ms_reg};
            pec_pkg::OFF_SCAN_WIN: rd_val = {16'h0, scan_win_reg};
            pec_pkg::OFF_STATUS: rd_val = {25'h0, act_reg, q_cap_reg.net[31],
               dv_state_reg == pec_pkg::DV_RUN, cap_ovf_reg};
            pec_pkg::OFF_IRQ_STAT: rd_val = {29'h0, irq_stat_reg};
            pec_pkg::OFF_IRQ_MASK: rd_val = {29'h0, irq_mask_reg};
            pec_pkg::OFF_QNET: rd_val = q_cap_reg.net;
            pec_pkg::OFF_QCW: rd_val = q_cap_reg.cw;
            pec_pkg::OFF_QCCW: rd_val = q_cap_reg.ccw;
            pec_pkg::OFF_PER_TIME: rd_val = pr_time_reg;
            pec_pkg::OFF_PER_NUM: rd_val = {16'h0, pr_num_reg};
            default: hit = 1'b0;
         endcase
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_val;
      end
   end
   assign pready = psel & penable;
   assign pslverr = psel & penable & !hit;

   AST_CAPTURE_CLEAR: assert property (scan_tick |=>
      cap_reg[0] == $past(cnt_reg[0]) && cnt_reg[0] <= 32'h1)
      else $error("capture or clear at scan tick wrong");
   AST_CONT_COUNT: assert property (!act_reg && !scan_tick && edge_ev[1] |=>
      cnt_reg[1] == $past(cnt_reg[1]) + 32'h1)
      else $error("edge lost between scans");
   AST_WRAP_FLAG: assert property (wrap_ev[2] |=>
      cnt_reg[2] == 32'h0 && ovf_reg[2] ##0 ovf_reg[2] [*1] ##1
      (ovf_reg[2] || $past(scan_tick)))
      else $error("overflow did not wrap or flag");
   AST_PER_IDLE: assert property (!act_reg && !scan_tick |=>
      $stable(pr_cyc_reg) && $stable(pr_n_reg))
      else $error("period path moved outside scan");
   AST_PER_CLOCK: assert property (act_reg && pr_started_reg && !scan_tick |=>
      pr_cyc_reg == $past(pr_cyc_reg) + 32'h1)
      else $error("period timer not counting clock cycles");
   AST_QX4_UP: assert property (ctrl_reg.quad_mode == pec_pkg::Q_X4 && one_step &&
      q_cw && !scan_tick |=> q_reg.net == $past(q_reg.net) + 32'h1 &&
      q_reg.cw == $past(q_reg.cw) + 32'h1)
      else $error("quadruple mode missed a forward edge");
   // single edge ignores forward A fall
   AST_QX1_FALL: assert property (ctrl_reg.quad_mode == pec_pkg::Q_X1 && one_step &&
      a_chg && !pulse_in[0] && q_cw && !scan_tick |=> $stable(q_reg))
      else $error("single mode counted a forward fall");
   AST_QX2_B: assert property (ctrl_reg.quad_mode == pec_pkg::Q_X2 && b_chg &&
      !a_chg && !scan_tick |=> $stable(q_reg.net))
      else $error("double mode counted a B edge");
   AST_DEBOUNCE: assert property (ctrl_reg.switch_closure_input[3] && edge_ev[3] |->
      !pulse_in[3] && $past(pulse_in[3]) == 1'b0 && $past(pulse_in[3], 8) == 1'b0)
      else $error("closure counted while bouncing");
   COV_TICK: cover property (scan_tick ##1 dv_start_reg);
   COV_WRAP: cover property (wrap_ev[0]);
   COV_DONE: cover property (scan_done);
   COV_PER: cover property (pr_fin_reg && pr_n_reg != 16'h0);
   COV_QDEC: cover property (q_dec);
endmodule

// >>> bench/pec_src.sv
// pulse sensor and shaft encoder model driving the pulse terminals
module pec_src (
   input wire logic mclk, // system clock
   output logic [3:0] pulse_out // sensor outputs, idle low
);
   timeunit 1ns;
   timeprecision 1ns;
   // encoder states as {b, a}, index rising means a leads b
   localparam logic [7:0] QSEQ = 8'hb4;
   int qi = 0;
   initial pulse_out = 4'h0;
   task automatic pulses(input int ch, input int n, input int per);
      for (int i = 0; i < n; i++) begin
         @(posedge mclk) pulse_out[ch] <= 1'b1;
         repeat (2) @(posedge mclk);
         pulse_out[ch] <= 1'b0;
         repeat (per - 3) @(posedge mclk);
      end
   endtask
   // hold one terminal at a level for n cycles
   task automatic level(input int ch, input bit v, input int n);
      @(posedge mclk) pulse_out[ch] <= v;
      repeat (n - 1) @(posedge mclk);
   endtask
   // forward has a leading b, reverse b leading a
   task automatic rotate(input int steps, input bit fwd);
      for (int i = 0; i < steps; i++) begin
         qi = fwd ? (qi + 1) % 4 : (qi + 3) % 4;
         @(posedge mclk) pulse_out[1:0] <= QSEQ[qi*2 +: 2];
         repeat (2) @(posedge mclk);
      end
   endtask
endmodule

// >>> bench/tb.sv
// self-checking bench of the pulse and encoder counter
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MSC = 10;
   // 50 ms scans, 500 cycles with the shortened millisecond
   localparam logic [31:0] SCAN_N = 32'h0000_0032;
   localparam logic [31:0] CTRL_CNT = 32'h0002_4801;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scan_active, irq;
   logic [3:0] pulse_in;
   logic [31:0] rdv;
   logic err;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   pec_top #(.MS_CYC(MSC)) i_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pulse_in(pulse_in), .scan_active(scan_active), .irq(irq));
   pec_src i_src (.mclk(mclk), .pulse_out(pulse_in));

   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one transfer; a gap cycle before setup keeps psel from toggling twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // clear pending events, then wait for the next scan results
   task automatic sync();
      wr(pec_pkg::OFF_IRQ_STAT, 32'h7);
      while (irq !== 1'b1) @(posedge mclk);
      wr(pec_pkg::OFF_IRQ_STAT, 32'h1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(rdv, exp);
   endtask

   task automatic t_reset();
      rdchk(pec_pkg::OFF_CTRL, pec_pkg::CTRL_RST);
      rdchk(pec_pkg::OFF_SCAN_MS, {16'h0, pec_pkg::SCAN_MS_RST});
      rdchk(pec_pkg::OFF_SCAN_WIN, {16'h0, pec_pkg::SCAN_WIN_RST});
      rd(8'h18);
      check({rdv[30:0], err}, 32'h1);
   endtask
   task automatic t_irq();
      wr(pec_pkg::OFF_SCAN_MS, SCAN_N);
      wr(pec_pkg::OFF_SCAN_WIN, 32'h64);
      wr(pec_pkg::OFF_CTRL, CTRL_CNT);
      repeat (700) @(posedge mclk);
      check({31'h0, irq}, 32'h0);
      rd(pec_pkg::OFF_IRQ_STAT);
      check({31'h0, rdv[0]}, 32'h1);
      wr(pec_pkg::OFF_IRQ_MASK, 32'h1);
      @(negedge mclk);
      check({31'h0, irq}, 32'h1);
      wr(pec_pkg::OFF_IRQ_STAT, 32'h1);
      @(negedge mclk);
      check({31'h0, irq}, 32'h0);
   endtask
   // counts, hertz and running average, then a scan with no pulses
   task automatic t_count();
      sync();
      fork
         i_src.pulses(2, 20, 4);
         i_src.pulses(3, 7, 6);
         i_src.pulses(1, 8, 5);
      join
      sync();
      rdchk(pec_pkg::OFF_RES0 + 8'h08, 32'd20);
      rdchk(pec_pkg::OFF_RES0 + 8'h0c, 32'd140);
      rdchk(pec_pkg::OFF_RES0 + 8'h04, 32'd40);
      sync();
      rdchk(pec_pkg::OFF_RES0 + 8'h08, 32'd0);
      rdchk(pec_pkg::OFF_RES0 + 8'h04, 32'd30);
   endtask
   // three turns forward and one back in each edge mode
   task automatic t_quad();
      logic [31:0] m;
      for (int md = 0; md < 3; md++) begin
         m = (md == 2) ? 32'd4 : 32'(md + 1);
         wr(pec_pkg::OFF_CTRL, CTRL_CNT | {28'h0, 2'(md), 2'b10});
         sync();
         i_src.rotate(12, 1'b1);
         i_src.rotate(4, 1'b0);
         sync();
         rdchk(pec_pkg::OFF_QNET, m * 2);
         rdchk(pec_pkg::OFF_QCW, m * 3);
         rdchk(pec_pkg::OFF_QCCW, m);
      end
      sync();
      i_src.rotate(8, 1'b0);
      sync();
      rdchk(pec_pkg::OFF_QNET, 32'hffff_fff8);
      rd(pec_pkg::OFF_STATUS);
      check({31'h0, rdv[5]}, 32'h1);
   endtask
   // bouncing closure on terminal 3 gives one count
   task automatic t_switch();
      i_src.level(3, 1'b1, 2100);
      wr(pec_pkg::OFF_SCAN_MS, 32'h0000_012c);
      wr(pec_pkg::OFF_CTRL, 32'h0000_0081);
      sync();
      i_src.level(3, 1'b0, 5);
      i_src.level(3, 1'b1, 5);
      i_src.level(3, 1'b0, 5);
      i_src.level(3, 1'b1, 5);
      i_src.level(3, 1'b0, 2100);
      i_src.level(3, 1'b1, 10);
      sync();
      rdchk(pec_pkg::OFF_RES0 + 8'h0c, 32'd1);
   endtask
   task automatic wait_win();
      while (scan_active !== 1'b1) @(posedge mclk);
   endtask
   task automatic t_period();
      sync();
      wait_win();
      i_src.pulses(2, 5, 10);
      while (scan_active !== 1'b0) @(posedge mclk);
      repeat (4) @(posedge mclk);
      rdchk(pec_pkg::OFF_PER_NUM, 32'd4);
      rdchk(pec_pkg::OFF_PER_TIME, 32'd40);
      rd(pec_pkg::OFF_IRQ_STAT);
      check({31'h0, rdv[2]}, 32'h1);
      i_src.pulses(2, 5, 10);
      wait_win();
      while (scan_active !== 1'b0) @(posedge mclk);
      repeat (4) @(posedge mclk);
      rdchk(pec_pkg::OFF_PER_NUM, 32'd0);
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_irq();
      t_count();
      t_quad();
      t_period();
      t_switch();
      give_verdict();
   end
endmodule
